// File: rtl/pef_flags.sv
// Peripheral event flag register, bits five down to one
`timescale 1ns/1ps

// Operation
// RULE1 - Bit 5 sets when timer B rolls to zero from its period.
// RULE2 - Bit 4 sets on timer A rollover; 16-bit mode uses the pair.
// RULE3 - Bit 3 sets on a capture event at capture pin B.
// RULE4 - Bit 2 sets on a capture event at capture pin A.
// RULE5 - Bit 1 is hardware controlled; software writes do not change it.
// RULE6 - Bit 1 is one when transmit buffer empty, zero when full.
// RULE7 - Register is 8 bits; bits 7, 6 and 0 belong elsewhere.
// RULE8 - Timer and capture flags clear by writing zero; set wins.
module pef_flags
  import pef_pkg::*;
(
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  // Register port
  input  wire logic [pef_pkg::PEF_AW-1:0] i_addr,
  input  wire logic [pef_pkg::PEF_DW-1:0] i_wr_data,
  input  wire logic i_wr,
  input  wire logic i_rd,
  output logic [pef_pkg::PEF_DW-1:0] o_rd_data,
  // Timers
  input  wire logic [pef_pkg::PEF_TW-1:0] i_timer_a_count,
  input  wire logic [pef_pkg::PEF_TW-1:0] i_timer_a_period,
  input  wire logic [pef_pkg::PEF_TW-1:0] i_timer_b_count,
  input  wire logic [pef_pkg::PEF_TW-1:0] i_timer_b_period,
  // Capture pins
  input  wire logic i_capture_a_pin,
  input  wire logic i_capture_b_pin,
  // Serial transmitter
  input  wire logic i_serial_a_tx_empty,
  // Flags and interrupt
  output logic [pef_pkg::PEF_DW-1:0] o_flags,
  output logic o_irq
);
  import pef_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [PEF_DW-1:0] flags_q, flags_d;
  logic [PEF_DW-1:0] stat_q, stat_d;
  logic [PEF_DW-1:0] en_q, en_d;
  logic mode16_q, mode16_d;
  logic [PEF_DW-1:0] rd_data_q, rd_data_d;
  logic irq_q, irq_d;
  logic [PEF_TW-1:0] ta_prev_q, ta_prev_d;
  logic [PEF_TW-1:0] tb_prev_q, tb_prev_d;
  logic tx_prev_q, tx_prev_d;
  logic [2:0] cap_a_s_q, cap_a_s_d;
  logic [2:0] cap_b_s_q, cap_b_s_d;
  logic cap_a_lvl_q, cap_a_lvl_d;
  logic cap_b_lvl_q, cap_b_lvl_d;

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  logic set_tb, set_ta, set_cap_a, set_cap_b, set_tx;
  logic [PEF_DW-1:0] hw_set;
  logic [PEF_DW-1:0] sw_clr;
  logic wr_flags;

  always_comb begin
    // Synchronisers; stage one feeds only stage two
    cap_a_s_d = {cap_a_s_q[1:0], i_capture_a_pin};
    cap_b_s_d = {cap_b_s_q[1:0], i_capture_b_pin};
    cap_a_lvl_d = cap_a_lvl_q;
    cap_b_lvl_d = cap_b_lvl_q;
    if (cap_a_s_q[1] == cap_a_s_q[2]) begin
      cap_a_lvl_d = cap_a_s_q[2];
    end
    if (cap_b_s_q[1] == cap_b_s_q[2]) begin
      cap_b_lvl_d = cap_b_s_q[2];
    end
    // Rising edge of the filtered level
    set_cap_a = !cap_a_lvl_q && cap_a_s_q[1] && cap_a_s_q[2]; // [RULE4]
    set_cap_b = !cap_b_lvl_q && cap_b_s_q[1] && cap_b_s_q[2]; // [RULE3]
    ta_prev_d = i_timer_a_count;
    tb_prev_d = i_timer_b_count;
    tx_prev_d = i_serial_a_tx_empty;
    // Rollover to zero from a count equal to the period
    set_tb = (tb_prev_q == i_timer_b_period) &&
             (i_timer_b_count == PEF_CNT_ZERO); // [RULE1]
    if (mode16_q) begin
      set_ta = ({tb_prev_q, ta_prev_q} ==
                {i_timer_b_period, i_timer_a_period}) &&
               ({i_timer_b_count, i_timer_a_count} ==
                PEF_PAIR_ZERO); // [RULE2]
    end else begin
      set_ta = (ta_prev_q == i_timer_a_period) &&
               (i_timer_a_count == PEF_CNT_ZERO); // [RULE2]
    end
    set_tx = i_serial_a_tx_empty && !tx_prev_q;
    hw_set = PEF_ZERO;
    hw_set[PEF_BIT_TIMER_B] = set_tb;
    hw_set[PEF_BIT_TIMER_A] = set_ta;
    hw_set[PEF_BIT_CAP_B] = set_cap_b;
    hw_set[PEF_BIT_CAP_A] = set_cap_a;
  end

  // ----------------------------------------------------------------
  // Event state registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ta_prev_q <= PEF_CNT_ZERO;
      tb_prev_q <= PEF_CNT_ZERO;
      tx_prev_q <= 1'b1;
      cap_a_s_q <= 3'h0;
      cap_b_s_q <= 3'h0;
      cap_a_lvl_q <= 1'b0;
      cap_b_lvl_q <= 1'b0;
    end else begin
      ta_prev_q <= ta_prev_d;
      tb_prev_q <= tb_prev_d;
      tx_prev_q <= tx_prev_d;
      cap_a_s_q <= cap_a_s_d;
      cap_b_s_q <= cap_b_s_d;
      cap_a_lvl_q <= cap_a_lvl_d;
      cap_b_lvl_q <= cap_b_lvl_d;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_comb begin
    wr_flags = i_wr && (i_addr == PEF_ADDR_FLAGS);
    sw_clr = PEF_ZERO;
    if (wr_flags) begin
      sw_clr = ~i_wr_data & PEF_SW_CLR_MASK; // [RULE8]
    end
    // Set takes precedence over a same-cycle clear
    flags_d = ((flags_q & ~sw_clr) | hw_set) & PEF_SW_CLR_MASK; // [RULE8]
    // Transmit flag mirrors buffer occupancy only
    flags_d[PEF_BIT_TX_A] = i_serial_a_tx_empty; // [RULE5] [RULE6]
    // Sticky event status
    stat_d = stat_q;
    en_d = en_q;
    mode16_d = mode16_q;
    if (i_wr && (i_addr == PEF_ADDR_CLR)) begin
      stat_d = stat_q & ~i_wr_data;
    end else if (i_wr && (i_addr == PEF_ADDR_EN)) begin
      en_d = i_wr_data & PEF_EVT_MASK;
    end else if (i_wr && (i_addr == PEF_ADDR_CTRL)) begin
      mode16_d = i_wr_data[PEF_BIT_MODE16];
    end
    stat_d = stat_d | hw_set;
    stat_d[PEF_BIT_TX_A] = stat_d[PEF_BIT_TX_A] | set_tx;
    stat_d = stat_d & PEF_EVT_MASK;
    irq_d = |(stat_d & en_d);
    // Read data in the following cycle
    rd_data_d = PEF_ZERO;
    if (i_rd) begin
      if (i_addr == PEF_ADDR_FLAGS) begin
        rd_data_d = flags_q; // [RULE7]
      end else if (i_addr == PEF_ADDR_STAT) begin
        rd_data_d = stat_q;
      end else if (i_addr == PEF_ADDR_EN) begin
        rd_data_d = en_q;
      end else if (i_addr == PEF_ADDR_CTRL) begin
        rd_data_d = PEF_ZERO;
        rd_data_d[PEF_BIT_MODE16] = mode16_q;
      end else begin
        rd_data_d = PEF_ZERO;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flag and status registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      flags_q <= PEF_FLAGS_RST;
      stat_q <= PEF_ZERO;
      en_q <= PEF_ZERO;
      mode16_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      stat_q <= stat_d;
      en_q <= en_d;
      mode16_q <= mode16_d;
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Read data register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rd_data_q <= PEF_ZERO;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  assign o_rd_data = rd_data_q;
  assign o_flags = flags_q;
  assign o_irq = irq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  timer_b_set_a: assert property ( // [RULE1]
    @(posedge i_clk_sys) disable iff (i_rst)
    (tb_prev_q == i_timer_b_period && i_timer_b_count == PEF_CNT_ZERO)
    |=> flags_q[PEF_BIT_TIMER_B])
  else $error("timer B flag missed a rollover");

  timer_a_pair_a: assert property ( // [RULE2]
    @(posedge i_clk_sys) disable iff (i_rst)
    (mode16_q && {tb_prev_q, ta_prev_q} ==
     {i_timer_b_period, i_timer_a_period} &&
     {i_timer_b_count, i_timer_a_count} == PEF_PAIR_ZERO)
    |=> flags_q[PEF_BIT_TIMER_A])
  else $error("timer A flag missed a pair rollover");

  timer_a_roll_a: assert property ( // [RULE2]
    @(posedge i_clk_sys) disable iff (i_rst)
    (!mode16_q && ta_prev_q == i_timer_a_period &&
     i_timer_a_count == PEF_CNT_ZERO)
    |=> flags_q[PEF_BIT_TIMER_A])
  else $error("timer A flag missed a rollover");

  timer_b_quiet_a: assert property ( // [RULE1]
    @(posedge i_clk_sys) disable iff (i_rst)
    $rose(flags_q[PEF_BIT_TIMER_B]) |->
    $past(tb_prev_q == i_timer_b_period && i_timer_b_count == PEF_CNT_ZERO))
  else $error("timer B flag set without rollover");

  cap_b_set_a: assert property ( // [RULE3]
    @(posedge i_clk_sys) disable iff (i_rst)
    $rose(cap_b_lvl_q) |-> flags_q[PEF_BIT_CAP_B])
  else $error("capture B edge did not set flag");

  cap_a_set_a: assert property ( // [RULE4]
    @(posedge i_clk_sys) disable iff (i_rst)
    $rose(cap_a_lvl_q) |-> flags_q[PEF_BIT_CAP_A])
  else $error("capture A edge did not set flag");

  cap_b_edge_a: assert property ( // [RULE3]
    @(posedge i_clk_sys) disable iff (i_rst)
    ($rose(cap_b_lvl_q) |-> $rose(flags_q[PEF_BIT_CAP_B]) ||
     $past(flags_q[PEF_BIT_CAP_B])) and
    ($rose(flags_q[PEF_BIT_CAP_B]) |-> $rose(cap_b_lvl_q)))
  else $error("capture B flag not tied to pin edge");

  cap_a_edge_a: assert property ( // [RULE4]
    @(posedge i_clk_sys) disable iff (i_rst)
    $rose(flags_q[PEF_BIT_CAP_A]) |-> $rose(cap_a_lvl_q))
  else $error("capture A flag set without pin edge");

  tx_no_sw_a: assert property ( // [RULE5]
    @(posedge i_clk_sys) disable iff (i_rst)
    (wr_flags && !i_serial_a_tx_empty && i_wr_data[PEF_BIT_TX_A])
    |=> !flags_q[PEF_BIT_TX_A])
  else $error("software changed transmit flag");

  tx_mirror_a: assert property ( // [RULE6]
    @(posedge i_clk_sys) disable iff (i_rst)
    !$past(i_rst) |-> flags_q[PEF_BIT_TX_A] == $past(i_serial_a_tx_empty))
  else $error("transmit flag does not mirror buffer");

  other_bits_a: assert property ( // [RULE7]
    @(posedge i_clk_sys) disable iff (i_rst)
    (i_rd && i_addr == PEF_ADDR_FLAGS) |=>
    (o_rd_data[PEF_BIT_PORT] == 1'b0 && o_rd_data[PEF_BIT_TIMER_C] == 1'b0
     && o_rd_data[PEF_BIT_RX_A] == 1'b0))
  else $error("unowned flag bits read nonzero");

  unowned_zero_a: assert property ( // [RULE7]
    @(posedge i_clk_sys) disable iff (i_rst)
    !flags_q[PEF_BIT_PORT] && !flags_q[PEF_BIT_TIMER_C] &&
    !flags_q[PEF_BIT_RX_A])
  else $error("unowned flag bits set");

  set_wins_a: assert property ( // [RULE8]
    @(posedge i_clk_sys) disable iff (i_rst)
    (wr_flags && set_tb && !i_wr_data[PEF_BIT_TIMER_B])
    |=> flags_q[PEF_BIT_TIMER_B] [*1] ##1 1'b1)
  else $error("clear beat a same-cycle set");

  flag_hold_a: assert property ( // [RULE8]
    @(posedge i_clk_sys) disable iff (i_rst)
    (flags_q[PEF_BIT_CAP_A] && !(wr_flags && !i_wr_data[PEF_BIT_CAP_A]))
    |=> flags_q[PEF_BIT_CAP_A])
  else $error("capture A flag dropped without clear");

  cap_b_hold_a: assert property ( // [RULE8]
    @(posedge i_clk_sys) disable iff (i_rst)
    (flags_q[PEF_BIT_CAP_B] && !(wr_flags && !i_wr_data[PEF_BIT_CAP_B]))
    |=> flags_q[PEF_BIT_CAP_B])
  else $error("capture B flag dropped without clear");

  timer_b_hold_a: assert property ( // [RULE8]
    @(posedge i_clk_sys) disable iff (i_rst)
    (flags_q[PEF_BIT_TIMER_B] && !(wr_flags && !i_wr_data[PEF_BIT_TIMER_B]))
    |=> flags_q[PEF_BIT_TIMER_B])
  else $error("timer B flag dropped without clear");

  timer_a_clr_a: assert property ( // [RULE8]
    @(posedge i_clk_sys) disable iff (i_rst)
    (wr_flags && !i_wr_data[PEF_BIT_TIMER_A] && !set_ta)
    |=> !flags_q[PEF_BIT_TIMER_A])
  else $error("timer A flag survived a clear");

endmodule // pef_flags

// File: rtl/pef_pkg.sv
// Constants for the peripheral event flag block
package pef_pkg;

  // ----------------------------------------------------------------
  // Bus widths
  // ----------------------------------------------------------------
  localparam int PEF_DW = 8;
  localparam int PEF_AW = 4;
  localparam int PEF_TW = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [PEF_AW-1:0] PEF_ADDR_FLAGS = 4'h0;
  localparam logic [PEF_AW-1:0] PEF_ADDR_STAT = 4'h1;
  localparam logic [PEF_AW-1:0] PEF_ADDR_CLR = 4'h2;
  localparam logic [PEF_AW-1:0] PEF_ADDR_EN = 4'h3;
  localparam logic [PEF_AW-1:0] PEF_ADDR_CTRL = 4'h4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PEF_BIT_PORT = 7;
  localparam int PEF_BIT_TIMER_C = 6;
  localparam int PEF_BIT_TIMER_B = 5;
  localparam int PEF_BIT_TIMER_A = 4;
  localparam int PEF_BIT_CAP_B = 3;
  localparam int PEF_BIT_CAP_A = 2;
  localparam int PEF_BIT_TX_A = 1;
  localparam int PEF_BIT_RX_A = 0;
  localparam int PEF_BIT_MODE16 = 0;

  // ----------------------------------------------------------------
  // Masks and reset values
  // ----------------------------------------------------------------
  localparam logic [PEF_DW-1:0] PEF_SW_CLR_MASK = 8'h3C;
  localparam logic [PEF_DW-1:0] PEF_EVT_MASK = 8'h3E;
  localparam logic [PEF_DW-1:0] PEF_FLAGS_RST = 8'h02;
  localparam logic [PEF_DW-1:0] PEF_ZERO = 8'h00;
  localparam logic [PEF_TW-1:0] PEF_CNT_ZERO = 8'h00;
  localparam logic [2*PEF_TW-1:0] PEF_PAIR_ZERO = 16'h0000;

endpackage : pef_pkg

// File: tb/pef_periph.sv
// Timer pair model driving the event flag block
`timescale 1ns/1ps
module pef_periph
  import pef_pkg::*;
(
  // Clock and control
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  input  wire logic i_run_a,
  input  wire logic i_run_b,
  input  wire logic i_mode16,
  input  wire logic [pef_pkg::PEF_TW-1:0] i_period_a,
  input  wire logic [pef_pkg::PEF_TW-1:0] i_period_b,
  // Counts
  output logic [pef_pkg::PEF_TW-1:0] o_count_a,
  output logic [pef_pkg::PEF_TW-1:0] o_count_b
);
  logic [2*PEF_TW-1:0] pair;
  assign pair = {o_count_b, o_count_a};
  // ----------------------------------------------------------------
  // Counters, cleared while stopped
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_count_a <= PEF_CNT_ZERO;
      o_count_b <= PEF_CNT_ZERO;
    end else if (i_mode16) begin
      // Pair rolls to zero after matching the period pair
      {o_count_b, o_count_a} <= (!i_run_a ||
        pair == {i_period_b, i_period_a}) ? 16'h0000 : pair + 16'h0001;
    end else begin
      // Each timer rolls to zero after matching its period
      o_count_a <= (!i_run_a || o_count_a == i_period_a) ?
        8'h00 : o_count_a + 8'h01;
      o_count_b <= (!i_run_b || o_count_b == i_period_b) ?
        8'h00 : o_count_b + 8'h01;
    end
  end
endmodule // pef_periph

// File: tb/test_pef_flags.sv
// Testbench for the peripheral event flag block
`timescale 1ns/1ps
module test_pef_flags;
  import pef_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic [PEF_AW-1:0] i_addr = 4'h0;
  logic [PEF_DW-1:0] i_wr_data = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic cap_a = 1'b0;
  logic cap_b = 1'b0;
  logic tx_empty = 1'b1;
  logic run_a = 1'b0;
  logic run_b = 1'b0;
  logic mode16 = 1'b0;
  logic [PEF_TW-1:0] per_a = 8'h05;
  logic [PEF_TW-1:0] per_b = 8'h03;
  logic [PEF_TW-1:0] cnt_a, cnt_b;
  logic [PEF_DW-1:0] o_rd_data, o_flags, rv;
  logic o_irq;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  always #2 i_clk_sys = ~i_clk_sys;
  pef_periph i_pef_periph (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_run_a(run_a), .i_run_b(run_b), .i_mode16(mode16),
    .i_period_a(per_a), .i_period_b(per_b),
    .o_count_a(cnt_a), .o_count_b(cnt_b));
  pef_flags i_pef_flags (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
    .o_rd_data(o_rd_data), .i_timer_a_count(cnt_a),
    .i_timer_a_period(per_a), .i_timer_b_count(cnt_b),
    .i_timer_b_period(per_b), .i_capture_a_pin(cap_a),
    .i_capture_b_pin(cap_b), .i_serial_a_tx_empty(tx_empty),
    .o_flags(o_flags), .o_irq(o_irq));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [PEF_DW-1:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [PEF_AW-1:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [PEF_AW-1:0] a);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    rv = o_rd_data;
  endtask
  task automatic wait_flag(input int idx, input int lim);
    for (int i = 0; i < lim && o_flags[idx] !== 1'b1; i++) begin
      @(posedge i_clk_sys);
      #1;
    end
  endtask
  task automatic stop_clear();
    @(posedge i_clk_sys);
    run_a <= 1'b0;
    run_b <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    wr(PEF_ADDR_FLAGS, 8'hC3);
  endtask
  task automatic pulse_a();
    @(posedge i_clk_sys);
    cap_a <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    cap_a <= 1'b1;
    repeat (6) @(posedge i_clk_sys);
    #1;
  endtask
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      wrap_up();
    end
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(posedge i_clk_sys);
    #1;
    check(o_flags, 8'h02);
    @(posedge i_clk_sys);
    run_b <= 1'b1;
    wait_flag(5, 20);
    check(o_flags, 8'h22);
    stop_clear();
    check(o_flags, 8'h02);
    @(posedge i_clk_sys);
    run_a <= 1'b1;
    wait_flag(4, 20);
    check(o_flags, 8'h12);
    stop_clear();
    wr(PEF_ADDR_CTRL, 8'h01);
    @(posedge i_clk_sys);
    run_a <= 1'b1;
    mode16 <= 1'b1;
    repeat (600) @(posedge i_clk_sys);
    #1;
    check(o_flags & 8'h10, 8'h00);
    wait_flag(4, 400);
    check(o_flags & 8'h10, 8'h10);
    stop_clear();
    wr(PEF_ADDR_CTRL, 8'h00);
    @(posedge i_clk_sys);
    cap_a <= 1'b1;
    mode16 <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    #1;
    check(o_flags, 8'h06);
    @(posedge i_clk_sys);
    cap_b <= 1'b1;
    repeat (6) @(posedge i_clk_sys);
    #1;
    check(o_flags, 8'h0E);
    @(posedge i_clk_sys);
    tx_empty <= 1'b0;
    wr(PEF_ADDR_FLAGS, 8'hFF);
    check(o_flags, 8'h0C);
    wr(PEF_ADDR_FLAGS, 8'h02);
    check(o_flags, 8'h00);
    @(posedge i_clk_sys);
    tx_empty <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    #1;
    check(o_flags, 8'h02);
    wr(PEF_ADDR_CLR, 8'h3E);
    wr(PEF_ADDR_EN, 8'h04);
    rd(PEF_ADDR_STAT);
    check(rv, 8'h00);
    check({7'h00, o_irq}, 8'h00);
    pulse_a();
    check({7'h00, o_irq}, 8'h01);
    rd(PEF_ADDR_STAT);
    check(rv, 8'h04);
    rd(PEF_ADDR_EN);
    check(rv, 8'h04);
    wr(PEF_ADDR_CLR, 8'h04);
    check({7'h00, o_irq}, 8'h00);
    wr(PEF_ADDR_EN, 8'h00);
    pulse_a();
    check({7'h00, o_irq}, 8'h00);
    rd(PEF_ADDR_STAT);
    check(rv, 8'h04);
    rd(4'hF);
    check(rv, 8'h00);
    wrap_up();
  end
endmodule // test_pef_flags
